//--- common/uim_pkg.sv
`default_nettype none
package uim_pkg;
   // ****************************************************************
   // register offsets on the peripheral access path
   // ****************************************************************
   localparam logic [7:0] OFF_SOFT_RESET = 8'h00;
   localparam logic [7:0] OFF_MODE       = 8'h04;
   localparam logic [7:0] OFF_DEV_ADDR   = 8'h08;
   localparam logic [7:0] OFF_FUNC       = 8'h0c;
   localparam logic [7:0] OFF_OTG_CTL    = 8'h10;
   localparam logic [7:0] OFF_OTG_STS    = 8'h14;
   localparam logic [7:0] OFF_SERIAL     = 8'h18;
   localparam logic [7:0] OFF_FLAGS      = 8'h1c;
   localparam logic [7:0] OFF_STICKY     = 8'h20;
   localparam logic [7:0] PERIPH_NUM     = 8'h01;
   // ****************************************************************
   // field layouts and values after reset
   // ****************************************************************
   localparam logic [7:0] MODE_MASK      = 8'hf7;
   localparam logic [7:0] OTG_MASK       = 8'hdf;
   localparam logic [7:0] MODE_RESET     = 8'h00;
   localparam logic [6:0] ADDR_RESET     = 7'h00;
   localparam logic [4:0] FUNC_RESET     = 5'h07;
   localparam logic [7:0] OTG_RESET      = 8'h00;
   localparam logic [3:0] SERIAL_RESET   = 4'h2;
   localparam logic [6:0] STICKY_RESET   = 7'h00;
   localparam int         NUM_FLAGS      = 7;
   localparam logic [6:0] FLAG_FOLLOWS   = 7'h3b;
   // ****************************************************************
   // line states, packet identifiers and check residues
   // ****************************************************************
   localparam logic [1:0]  LS_SE0      = 2'h0;
   localparam logic [1:0]  LS_J        = 2'h1;
   localparam logic [1:0]  LS_K        = 2'h2;
   localparam logic [1:0]  PID_TOKEN   = 2'h1;
   localparam logic [1:0]  PID_DATA    = 2'h3;
   localparam logic [3:0]  PID_SOF     = 4'h5;
   localparam logic [4:0]  CRC5_INIT   = 5'h1f;
   localparam logic [4:0]  CRC5_POLY   = 5'h05;
   localparam logic [4:0]  CRC5_RESID  = 5'h0c;
   localparam logic [15:0] CRC16_INIT  = 16'hffff;
   localparam logic [15:0] CRC16_POLY  = 16'h8005;
   localparam logic [15:0] CRC16_RESID = 16'h800d;
   typedef enum logic [1:0] {
      TK_IDLE = 2'h0,
      TK_PID  = 2'h1,
      TK_B1   = 2'h3,
      TK_B2   = 2'h2
   } uim_tok_state_t;
endpackage
`default_nettype wire

//--- logic/uim_flag_bit.sv
`timescale 1ns/10ps
`default_nettype none
module uim_flag_bit (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic swReset,
   input  wire logic follows,
   input  wire logic sticky,
   input  wire logic event_in,
   input  wire logic pktStart,
   input  wire logic clrWr,
   output logic      value
);
   typedef struct packed {logic v;} uim_flag_t;
   uim_flag_t st_r;
   uim_flag_t st_nxt;

   // set beats a clear write or packet start arriving in the same cycle; only soft reset beats set
   always_comb begin
      st_nxt = st_r;
      if (sticky) begin
         if (clrWr) st_nxt.v = 1'b0;
      end else if (follows) begin
         st_nxt.v = 1'b0;
      end else if (pktStart || clrWr) begin
         st_nxt.v = 1'b0;
      end
      if (event_in) st_nxt.v = 1'b1;
      if (swReset) st_nxt.v = 1'b0;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign value = st_r.v;
endmodule
`default_nettype wire

//--- logic/uim_regs.sv
// Operation
// - any write to offset 0x00 returns all manager state but activePrev to reset values; activePrev copies rxActive
// - seven-bit device address; only packets for that address are passed on
// - mode word enables token, check, linestate, timing, power, sof, ack modes
// - functional word drives opmode, termselect, xcvrselect; all reset to one
// - on-the-go word drives pull, vbus charge and external vbus outputs
// - on-the-go status word reads live transceiver session and id inputs
// - serial word drives serial mode, tx data, tx se0, active-low tx enable
// - serial word reads back receive dp, dm and differential receiver
// - flag six set on token passing address match, and crc5 and pid check when check mode is on
// - flags three, four, five show linestate j, k and se0
// - flag two set when a data packet fails its crc16 check
// - flag one follows rx active, flag zero follows rx error
// - non-sticky flags two and six clear on next packet; sticky ones wait for software
// - bank is peripheral one, reached by 32-bit reads and writes only
// - sticky flag holds until software writes one to its position
`timescale 1ns/10ps
`default_nettype none
module uim_regs (
   input  wire logic        clock,
   input  wire logic        resetn,
   // peripheral access path
   input  wire logic [7:0]  perNum,
   input  wire logic        perWrite,
   input  wire logic        perRead,
   input  wire logic [7:0]  perAddr,
   input  wire logic [31:0] perWdata,
   output logic [31:0]      perRdata,
   output logic             perRdValid,
   // transceiver receive side
   input  wire logic [7:0]  rxData,
   input  wire logic        rxValid,
   input  wire logic        rxActive,
   input  wire logic        rxError,
   input  wire logic [1:0]  lineState,
   input  wire logic        sessEnd,
   input  wire logic        sessVld,
   input  wire logic        vbusValid,
   input  wire logic        hostDisconnect,
   input  wire logic        idGnd,
   input  wire logic        bValid,
   input  wire logic        rxDp,
   input  wire logic        rxDm,
   input  wire logic        rxRcv,
   // transceiver control side
   output logic [2:0]       opMode,
   output logic             termSelect,
   output logic             xcvrSelect,
   output logic             idPullup,
   output logic             dpPulldown,
   output logic             dmPulldown,
   output logic             dischrgVbus,
   output logic             chrgVbus,
   output logic             externalVbusDrive,
   output logic             externalVbusIndicator,
   output logic             fsLsSerialMode,
   output logic             txDat,
   output logic             txSe0,
   output logic             txEnable_n,
   // mode enables handed to the interface state machine
   output logic             ifTimingMode,
   output logic             powerSignalMode,
   output logic             eventAckMode,
   // forwarded receive data and flags
   output logic [7:0]       fwdData,
   output logic             fwdValid,
   output logic [6:0]       flags
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  mode;
      logic [6:0]  devAddr;
      logic [4:0]  func;
      logic [7:0]  otg;
      logic [3:0]  serial;
      logic [6:0]  sticky;
      logic [31:0] rdata;
      logic        rdValid;
      logic        activePrev;
      logic        pidTaken;
      logic [7:0]  dataPid;
      logic [15:0] crc16;
      logic        crcFail;
      logic [7:0]  fwdData;
      logic        fwdValid;
   } uim_regs_t;
   uim_regs_t st_r;
   uim_regs_t st_nxt;

   logic       sel;
   logic       wrHit;
   logic       rdHit;
   logic       swReset;
   logic       pktStart;
   logic       tokenOk;
   logic       tokenMatch;
   logic [6:0] flagVal;
   logic [6:0] flagEv;
   logic [6:0] flagClr;
   logic       lsDec;

   // ****************************************************************
   // access decode
   // ****************************************************************
   // other peripheral numbers share the path and must be left alone
   assign sel = (perNum == uim_pkg::PERIPH_NUM);
   assign wrHit = sel && perWrite;
   assign rdHit = sel && perRead;
   // data value is ignored: the address alone triggers the soft reset
   assign swReset = wrHit && (perAddr == uim_pkg::OFF_SOFT_RESET);
   assign pktStart = rxActive && !st_r.activePrev;
   assign lsDec = st_r.mode[2];

   // ****************************************************************
   // serial crc16 over the data payload, least significant bit first
   // ****************************************************************
   function automatic logic [15:0] crc16Byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? uim_pkg::CRC16_POLY : 16'h0000);
      end
      return r;
   endfunction

   // ****************************************************************
   // token checker
   // ****************************************************************
   uim_token_check u_tok (
      .clock      (clock),
      .resetn     (resetn),
      .swReset    (swReset),
      .rxData     (rxData),
      .rxValid    (rxValid),
      .rxActive   (rxActive),
      .devAddr    (st_r.devAddr),
      .tokenProc  (st_r.mode[0]),
      .tokenCheck (st_r.mode[1]),
      .frame_start_as_token (st_r.mode[6]),
      .tokenOk    (tokenOk),
      .tokenMatch (tokenMatch)
   );

   // ****************************************************************
   // signal flags
   // ****************************************************************
   // linestate bits only react while the decoder is enabled
   always_comb begin
      flagEv = '0;
      flagEv[0] = rxError;
      flagEv[1] = rxActive;
      flagEv[2] = st_r.crcFail;
      flagEv[3] = lsDec && (lineState == uim_pkg::LS_J);
      flagEv[4] = lsDec && (lineState == uim_pkg::LS_K);
      flagEv[5] = lsDec && (lineState == uim_pkg::LS_SE0);
      flagEv[6] = tokenOk;
      flagClr = (wrHit && perAddr == uim_pkg::OFF_FLAGS) ? perWdata[6:0] : 7'h00;
   end

   // one cell per flag; the mix of level and event bits is fixed per position
   for (genvar g = 0; g < uim_pkg::NUM_FLAGS; g++) begin : g_flag
      uim_flag_bit u_flag (
         .clock    (clock),
         .resetn   (resetn),
         .swReset  (swReset),
         .follows  (uim_pkg::FLAG_FOLLOWS[g]),
         .sticky   (st_r.sticky[g]),
         .event_in (flagEv[g]),
         .pktStart (pktStart),
         .clrWr    (flagClr[g]),
         .value    (flagVal[g])
      );
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdValid = 1'b0;
      st_nxt.crcFail = 1'b0;
      st_nxt.fwdValid = 1'b0;
      st_nxt.activePrev = rxActive;

      // register writes; reserved bits are masked off
      if (wrHit) begin
         case (perAddr)
            uim_pkg::OFF_MODE:     st_nxt.mode = perWdata[7:0] & uim_pkg::MODE_MASK;
            uim_pkg::OFF_DEV_ADDR: st_nxt.devAddr = perWdata[6:0];
            uim_pkg::OFF_FUNC:     st_nxt.func = perWdata[4:0];
            uim_pkg::OFF_OTG_CTL:  st_nxt.otg = perWdata[7:0] & uim_pkg::OTG_MASK;
            uim_pkg::OFF_SERIAL:   st_nxt.serial = perWdata[3:0];
            uim_pkg::OFF_STICKY:   st_nxt.sticky = perWdata[6:0];
            default:               st_nxt.mode = st_r.mode;
         endcase
      end

      // reads answer one cycle later; unmapped and write-only read zero
      if (rdHit) begin
         st_nxt.rdValid = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
         case (perAddr)
            uim_pkg::OFF_MODE:     st_nxt.rdata[7:0] = st_r.mode;
            uim_pkg::OFF_DEV_ADDR: st_nxt.rdata[6:0] = st_r.devAddr;
            uim_pkg::OFF_FUNC:     st_nxt.rdata[4:0] = st_r.func;
            uim_pkg::OFF_OTG_CTL:  st_nxt.rdata[7:0] = st_r.otg;
            uim_pkg::OFF_OTG_STS:  st_nxt.rdata[5:0] =
               {bValid, idGnd, hostDisconnect, vbusValid, sessVld, sessEnd};
            uim_pkg::OFF_SERIAL:   st_nxt.rdata[6:0] =
               {rxRcv, rxDm, rxDp, st_r.serial};
            uim_pkg::OFF_FLAGS:    st_nxt.rdata[6:0] = flagVal;
            uim_pkg::OFF_STICKY:   st_nxt.rdata[6:0] = st_r.sticky;
            default:               st_nxt.rdata = 32'h0000_0000;
         endcase
      end

      // receive path: first byte is the identifier, the rest feed crc16
      if (rxActive && rxValid) begin
         if (!st_r.pidTaken) begin
            st_nxt.pidTaken = 1'b1;
            st_nxt.dataPid = rxData;
            st_nxt.crc16 = uim_pkg::CRC16_INIT;
         end else begin
            st_nxt.crc16 = crc16Byte(st_r.crc16, rxData);
            // payload reaches the core only after a token for our address
            if (st_r.dataPid[1:0] == uim_pkg::PID_DATA && tokenMatch) begin
               st_nxt.fwdValid = 1'b1;
               st_nxt.fwdData = rxData;
            end
         end
      end

      // verdict at packet end; crc trailer is forwarded with the payload
      if (!rxActive && st_r.pidTaken) begin
         st_nxt.pidTaken = 1'b0;
         st_nxt.crcFail = (st_r.dataPid[1:0] == uim_pkg::PID_DATA)
                          && (st_r.crc16 != uim_pkg::CRC16_RESID);
      end

      // soft reset returns the transceiver control words to reset values along with us
      if (swReset) begin
         st_nxt = '0;
         st_nxt.mode = uim_pkg::MODE_RESET;
         st_nxt.devAddr = uim_pkg::ADDR_RESET;
         st_nxt.func = uim_pkg::FUNC_RESET;
         st_nxt.otg = uim_pkg::OTG_RESET;
         st_nxt.serial = uim_pkg::SERIAL_RESET;
         st_nxt.sticky = uim_pkg::STICKY_RESET;
         st_nxt.activePrev = rxActive;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
         st_r.mode <= uim_pkg::MODE_RESET;
         st_r.devAddr <= uim_pkg::ADDR_RESET;
         st_r.func <= uim_pkg::FUNC_RESET;
         st_r.otg <= uim_pkg::OTG_RESET;
         st_r.serial <= uim_pkg::SERIAL_RESET;
         st_r.sticky <= uim_pkg::STICKY_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************************************
   // outputs, all straight from flops
   // ****************************************************************
   // opmode stays three bits wide as stored; the phy uses what it needs
   assign opMode = st_r.func[4:2];
   assign termSelect = st_r.func[1];
   assign xcvrSelect = st_r.func[0];
   assign idPullup = st_r.otg[0];
   assign dpPulldown = st_r.otg[1];
   assign dmPulldown = st_r.otg[2];
   assign dischrgVbus = st_r.otg[3];
   assign chrgVbus = st_r.otg[4];
   assign externalVbusDrive = st_r.otg[6];
   assign externalVbusIndicator = st_r.otg[7];
   assign fsLsSerialMode = st_r.serial[0];
   assign txEnable_n = st_r.serial[1];
   assign txDat = st_r.serial[2];
   assign txSe0 = st_r.serial[3];
   assign ifTimingMode = st_r.mode[4];
   assign powerSignalMode = st_r.mode[5];
   assign eventAckMode = st_r.mode[7];
   assign perRdata = st_r.rdata;
   assign perRdValid = st_r.rdValid;
   assign fwdData = st_r.fwdData;
   assign fwdValid = st_r.fwdValid;
   assign flags = flagVal;
endmodule
`default_nettype wire

//--- logic/uim_token_check.sv
`timescale 1ns/10ps
`default_nettype none
module uim_token_check (
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       swReset,
   input  wire logic [7:0] rxData,
   input  wire logic       rxValid,
   input  wire logic       rxActive,
   input  wire logic [6:0] devAddr,
   input  wire logic       tokenProc,
   input  wire logic       tokenCheck,
   input  wire logic       frame_start_as_token,
   output logic            tokenOk,
   output logic            tokenMatch
);
   typedef struct packed {
      uim_pkg::uim_tok_state_t tk;
      logic [7:0]              pid;
      logic [7:0]              b1;
      logic [4:0]              crc;
      logic                    extra;
      logic                    ok;
      logic                    match;
   } uim_tok_t;
   uim_tok_t st_r;
   uim_tok_t st_nxt;

   // serial crc5, least significant bit first as on the wire
   function automatic logic [4:0] crc5Byte(input logic [4:0] c, input logic [7:0] d);
      logic [4:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = {r[3:0], 1'b0} ^ ((r[4] ^ d[i]) ? uim_pkg::CRC5_POLY : 5'h00);
      end
      return r;
   endfunction

   logic isSof;
   logic good;
   // a token is good only with exactly two bytes after its identifier
   always_comb begin
      isSof = (st_r.pid[3:0] == uim_pkg::PID_SOF);
      good = (st_r.pid[1:0] == uim_pkg::PID_TOKEN) && (st_r.tk == uim_pkg::TK_B2)
             && !st_r.extra
             && (!tokenCheck || ((st_r.pid[3:0] == ~st_r.pid[7:4])
                 && (st_r.crc == uim_pkg::CRC5_RESID)))
             && (isSof ? frame_start_as_token : (st_r.b1[6:0] == devAddr));
   end

   // walk identifier and two token bytes, judge at end of packet
   always_comb begin
      st_nxt = st_r;
      st_nxt.ok = 1'b0;
      if (rxActive && rxValid) begin
         case (st_r.tk)
            uim_pkg::TK_IDLE: begin
               st_nxt.tk = uim_pkg::TK_PID;
               st_nxt.pid = rxData;
               st_nxt.crc = uim_pkg::CRC5_INIT;
               st_nxt.extra = 1'b0;
            end
            uim_pkg::TK_PID: begin
               st_nxt.tk = uim_pkg::TK_B1;
               st_nxt.b1 = rxData;
               st_nxt.crc = crc5Byte(st_r.crc, rxData);
            end
            uim_pkg::TK_B1: begin
               st_nxt.tk = uim_pkg::TK_B2;
               st_nxt.crc = crc5Byte(st_r.crc, rxData);
            end
            default: st_nxt.extra = 1'b1;
         endcase
      end else if (!rxActive && st_r.tk != uim_pkg::TK_IDLE) begin
         st_nxt.tk = uim_pkg::TK_IDLE;
         st_nxt.ok = tokenProc && good;
         if (st_r.pid[1:0] == uim_pkg::PID_TOKEN && !isSof) st_nxt.match = good;
      end
      if (swReset) st_nxt = '0;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign tokenOk = st_r.ok;
   assign tokenMatch = st_r.match;
endmodule
`default_nettype wire

//--- test/uim_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module uim_phy_model (
   input  wire logic  clock,
   output logic [7:0] rxData,
   output logic       rxValid,
   output logic       rxActive,
   output logic       rxError,
   output logic [1:0] lineState,
   output logic [8:0] status
);
   // idle line J, nothing received
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      rxActive = 1'b0;
      rxError = 1'b0;
      lineState = 2'h1;
      status = 9'h000;
   end
   // levels settle for three edges before anyone looks
   task automatic setLine(input logic [1:0] ls, input logic err, input logic [8:0] st);
      lineState <= ls;
      rxError <= err;
      status <= st;
      repeat (3) @(posedge clock);
   endtask
   // bytes go out low byte first, one per edge
   task automatic send(input logic [31:0] b, input int n);
      rxActive <= 1'b1;
      for (int i = 0; i < n; i++) begin
         rxValid <= 1'b1;
         rxData <= b[8*i +: 8];
         @(posedge clock);
      end
      rxActive <= 1'b0;
      rxValid <= 1'b0;
      rxData <= ~b[8*n-8 +: 8]; // stale byte not left on the bus
      repeat (4) @(posedge clock); // gap before next packet
   endtask
endmodule
`default_nettype wire

//--- test/uim_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module uim_regs_monitor (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic [7:0]  perNum,
   input wire logic        perWrite,
   input wire logic        perRead,
   input wire logic [7:0]  perAddr,
   input wire logic [31:0] perWdata,
   input wire logic [31:0] perRdata,
   input wire logic        perRdValid,
   input wire logic        rxActive,
   input wire logic [2:0]  opMode,
   input wire logic        termSelect,
   input wire logic        xcvrSelect,
   input wire logic        fsLsSerialMode,
   input wire logic        txDat,
   input wire logic        txSe0,
   input wire logic        txEnable_n,
   input wire logic        ifTimingMode,
   input wire logic        powerSignalMode,
   input wire logic        eventAckMode,
   input wire logic [6:0]  flags
);
   // **************************************
   // strobes aimed at this bank
   // **************************************
   logic wrSel;
   logic rdSel;
   assign wrSel = perWrite && perNum == 8'h01;
   assign rdSel = perRead && perNum == 8'h01;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // a read in the soft reset cycle is lost, so it is left out
   property p_rdAnswer; rdSel && !(wrSel && perAddr == 8'h00) |=> perRdValid; endproperty
   a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");
   property p_noAnswer; !rdSel |=> !perRdValid; endproperty
   a_noAnswer: assert property (p_noAnswer) else $error("answer without read");
   property p_func;
      wrSel && perAddr == 8'h0c |=> {opMode, termSelect, xcvrSelect} == $past(perWdata[4:0]);
   endproperty
   a_func: assert property (p_func) else $error("function outputs wrong");
   property p_serial;
      wrSel && perAddr == 8'h18 |=>
         {txSe0, txDat, txEnable_n, fsLsSerialMode} == $past(perWdata[3:0]);
   endproperty
   a_serial: assert property (p_serial) else $error("serial outputs wrong");
   property p_mode;
      wrSel && perAddr == 8'h04 |=> {eventAckMode, powerSignalMode, ifTimingMode} ==
         {$past(perWdata[7]), $past(perWdata[5:4])};
   endproperty
   a_mode: assert property (p_mode) else $error("mode outputs wrong");
   property p_softReset;
      wrSel && perAddr == 8'h00 |=> opMode == 3'h1 && termSelect && xcvrSelect &&
         txEnable_n && !eventAckMode && flags == 7'h00;
   endproperty
   a_softReset: assert property (p_softReset) else $error("soft reset incomplete");
   property p_reserved; perRdValid |-> perRdata[31:8] == 24'h000000; endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   // two cycles allowed for the flag cell to pick up the level
   property p_active; (rxActive && !wrSel)[*3] |-> flags[1]; endproperty
   a_active: assert property (p_active) else $error("active flag missing");
endmodule
bind uim_regs uim_regs_monitor mon (.*);
`default_nettype wire

//--- test/usb_iface_manager_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module usb_iface_manager_regs_test;
   logic        clock, resetn, perWrite, perRead, perRdValid, fwdValid, rxValid, rxActive;
   logic        rxError, sessEnd, sessVld, vbusValid, hostDisconnect, idGnd, bValid, rxDp;
   logic        rxDm, rxRcv, termSelect, xcvrSelect, idPullup, dpPulldown, dmPulldown;
   logic        dischrgVbus, chrgVbus, externalVbusDrive, externalVbusIndicator, txDat;
   logic        fsLsSerialMode, txSe0, txEnable_n, ifTimingMode, powerSignalMode, eventAckMode;
   logic [7:0]  perNum, perAddr, rxData, fwdData;
   logic [31:0] perWdata, perRdata;
   logic [1:0]  lineState;
   logic [2:0]  opMode;
   logic [6:0]  flags;
   logic [8:0]  status;
   logic [7:0]  otgPins;
   logic [7:0]  offs [5] = '{8'h04, 8'h0c, 8'h10, 8'h18, 8'h14};
   logic [31:0] exps [5] = '{32'hf7, 32'h1f, 32'hdf, 32'h0f, 32'h00};
   logic [1:0]  lsv [3] = '{2'h1, 2'h2, 2'h0};
   int          nMismatch = 0;
   int          checks = 0;
   int          fwdCount = 0;
   int          base;
   uim_regs dut (.*);
   uim_phy_model phy (.*);
   assign {rxRcv, rxDm, rxDp, bValid, idGnd, hostDisconnect, vbusValid, sessVld, sessEnd} = status;
   // on-the-go pins packed in register order, gap for the reserved bit
   assign otgPins = {externalVbusIndicator, externalVbusDrive, 1'b0, chrgVbus, dischrgVbus,
                     dmPulldown, dpPulldown, idPullup};
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // forwarded bytes counted, not checked one by one
   always @(posedge clock) if (fwdValid === 1'b1) fwdCount <= fwdCount + 1;
   // *****************************************
   // access tasks
   // *****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [7:0] per = 8'h01);
      perNum <= per;
      perAddr <= a;
      perWdata <= d;
      perWrite <= 1'b1;
      @(posedge clock);
      perWrite <= 1'b0;
      @(posedge clock);
   endtask
   // read data lands exactly one edge after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      perNum <= 8'h01;
      perAddr <= a;
      perRead <= 1'b1;
      @(posedge clock);
      perRead <= 1'b0;
      #1;
      chk(what, exp, perRdata);
      @(posedge clock);
   endtask
   task automatic wrapUp;
      $display("comparisons %0d, mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      nMismatch++;
      wrapUp();
   end
   // *****************************************
   // main sequence
   // *****************************************
   initial begin
      resetn = 1'b0;
      perNum = 8'h00;
      perAddr = 8'h00;
      perWdata = 32'h0;
      perWrite = 1'b0;
      perRead = 1'b0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      rd(8'h0c, 32'h7, "function word");
      rd(8'h18, 32'h2, "serial word");
      rd(8'h08, 32'h0, "device address");
      rd(8'h40, 32'h0, "unmapped");
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], '1);
         rd(offs[i], exps[i], "all ones");
      end
      chk("otg pins", 32'hdf, {24'h0, otgPins});
      wr(8'h0c, 32'h0, 8'h02);
      rd(8'h0c, 32'h1f, "other bank");
      $display("test register access done");
      wr(8'h00, 32'h5a5a5a5a);
      rd(8'h0c, 32'h7, "function after soft reset");
      rd(8'h04, 32'h0, "mode after soft reset");
      chk("otg pins after soft reset", 32'h0, {24'h0, otgPins});
      phy.setLine(2'h1, 1'b1, 9'h1ff);
      rd(8'h14, 32'h3f, "otg status");
      rd(8'h18, 32'h72, "serial receive");
      rd(8'h1c, 32'h01, "error flag");
      wr(8'h04, 32'h4);
      for (int i = 0; i < 3; i++) begin
         phy.setLine(lsv[i], 1'b0, 9'h000);
         rd(8'h1c, 32'h8 << i, "linestate flag");
      end
      phy.setLine(2'h1, 1'b0, 9'h000);
      $display("test inputs and linestate done");
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h5);
      phy.send(32'h0005e1, 3);
      rd(8'h1c, 32'h40, "token flag");
      base = fwdCount;
      phy.send(32'ha50001c3, 4);
      rd(8'h1c, 32'h04, "crc flag");
      chk("forwarded", 32'h1, {31'h0, fwdCount > base});
      chk("forwarded byte", 32'ha5, {24'h0, fwdData});
      phy.send(32'h0006e1, 3);
      base = fwdCount;
      phy.send(32'h000001c3, 4);
      chk("dropped", base, fwdCount);
      $display("test packets done");
      wr(8'h20, 32'h40);
      phy.send(32'h0005e1, 3);
      phy.send(32'h000001c3, 4);
      rd(8'h1c, 32'h44, "sticky flags");
      wr(8'h1c, 32'h40);
      rd(8'h1c, 32'h04, "cleared flags");
      // identifier check on: a token whose check nibble is wrong must not flag
      wr(8'h04, 32'h3);
      phy.send(32'h0005f1, 3);
      rd(8'h1c, 32'h00, "bad pid token");
      $display("test sticky done");
      wrapUp();
   end
endmodule
`default_nettype wire
